/* mtb_pin_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: i_pin is asynchronous to i_core_clk
// Notes:   level resets low, so a pin high at reset gives one rise pulse
`timescale 1ns/10ps
module mtb_pin_sync (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  // pin and filtered result
  input  wire logic i_pin,
  mtb_sync_if.src   o_sync
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } mtb_sync_st_t;

  mtb_sync_st_t s_q;
  mtb_sync_st_t s_d;
  logic         agree;

  always_comb begin
    s_d      = s_q;
    s_d.s1   = i_pin;
    s_d.s2   = s_q.s1;
    s_d.s3   = s_q.s2;
    // s1 feeds only s2: the filter looks at stages two and three
    agree    = (s_q.s2 == s_q.s3);
    if (agree) begin
      s_d.lvl = s_q.s3;
    end
    o_sync.level = s_q.lvl;
    o_sync.rise  = agree && s_q.s3 && !s_q.lvl;
    o_sync.fall  = agree && !s_q.s3 && s_q.lvl;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* mtb_pkg.sv */
// Purpose: shared constants, types and helpers of the two-channel measuring timer
// Assumes: 32-bit AHB-Lite word registers, byte addresses below 0x100
// Notes:   one register word per offset, unused upper bits read as zero
package mtb_pkg;

  localparam int unsigned NUM_CH = 2;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_MODE0 = 8'h04;
  localparam logic [7:0] OFF_TMR0  = 8'h08;
  localparam int         OFF_STEP  = 8;
  localparam logic [7:0] OFF_NONE  = 8'hFC;

  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int EDGE_LSB = 2;
  localparam int SRC_LSB  = 4;
  localparam int OVF_POS  = 7;

  // reset values and counter maximum
  localparam logic [1:0]  START_RST = 2'h0;
  localparam logic [5:0]  MODE_RST  = 6'h00;
  localparam logic [15:0] TMR_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;

  // prescaler ratios
  localparam int DIV8  = 8;
  localparam int DIV32 = 32;

  typedef enum logic [1:0] {MTB_TIMER, MTB_EVENT, MTB_MEAS, MTB_RSVD} mtb_mode_t;
  typedef enum logic [1:0] {SRC_F1, SRC_F8, SRC_F32, SRC_SUB32} mtb_src_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} mtb_edge_t;

  function automatic logic [7:0] mode_off(input int ch);
    return 8'(int'(OFF_MODE0) + ch * OFF_STEP);
  endfunction

  function automatic logic [7:0] tmr_off(input int ch);
    return 8'(int'(OFF_TMR0) + ch * OFF_STEP);
  endfunction

  function automatic logic sel_tick(input logic [1:0] src, input logic t8, input logic t32,
                                    input logic tsub);
    case (src)
      SRC_F1:  return 1'b1;
      SRC_F8:  return t8;
      SRC_F32: return t32;
      default: return tsub;
    endcase
  endfunction

  function automatic logic eff_edge(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      EDGE_RISE: return rise;
      EDGE_FALL: return fall;
      EDGE_BOTH: return rise | fall;
      default:   return 1'b0;
    endcase
  endfunction

endpackage

/* mtb_pulse_src.sv */
// Purpose: square-wave source on the two channel pins
// Assumes: run and half period come from the bench on the core clock
// Notes:   a stopped source holds its pin level, as a quiet signal line would
`timescale 1ns/10ps
module mtb_pulse_src (
  // clock
  input  wire logic        i_core_clk,
  // control from the bench
  input  wire logic [1:0]  i_run,
  input  wire logic [15:0] i_half,
  // channel pins
  output logic      [1:0]  o_pin
);
  logic [15:0] cnt_q [2];

  initial begin
    o_pin    = 2'h0;
    cnt_q[0] = 16'h0001;
    cnt_q[1] = 16'h0001;
  end

  // phase restarts on each run, so the first edge lands one half period later
  always @(posedge i_core_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!i_run[c] || cnt_q[c] == i_half) cnt_q[c] <= 16'h0001;
      else cnt_q[c] <= cnt_q[c] + 16'h0001;
      if (i_run[c] && cnt_q[c] == i_half) o_pin[c] <= ~o_pin[c];
    end
  end
endmodule

/* mtb_sync_if.sv */
// Purpose: carries a filtered pin level and its edge pulses
// Assumes: one core clock
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/10ps
interface mtb_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* mtb_timer_top.sv */
// Purpose: two 16-bit timer channels: timer, event counter, pulse measurement
// Assumes: 20 MHz core clock, AHB-Lite slave, whole-word single transfers
// Notes:   writes take no wait state, reads take one
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps

module mtb_timer_top (
  // clock and reset
  input  wire  logic        i_core_clk,
  input  wire  logic        i_rst_b,
  // ahb-lite slave
  input  wire  logic        i_hsel,
  input  wire  logic [31:0] i_haddr,
  input  wire  logic [1:0]  i_htrans,
  input  wire  logic        i_hwrite,
  input  wire  logic [2:0]  i_hsize,
  input  wire  logic [31:0] i_hwdata,
  input  wire  logic        i_hready,
  output logic [31:0]       o_hrdata,
  output logic              o_hreadyout,
  output logic              o_hresp,
  // pins
  input  wire  logic [1:0]  i_channel_pulse_input_pin,
  input  wire  logic        i_sub_clock_pin,
  // interrupt requests, one per channel
  output logic [1:0]        o_irq_req
);

  typedef struct packed {
    logic             act;
    logic             wr;
    logic             rd_wait;
    logic [7:0]       addr;
    logic [31:0]      rdata;
    logic [4:0]       presc;
    logic [4:0]       subdiv;
    logic [1:0]       start;
    logic [1:0][5:0]  mode;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] rld;
    logic [1:0]       ovf;
    logic [1:0]       seen;
    logic [1:0]       irq;
  } mtb_state_t;

  mtb_state_t s_q;
  mtb_state_t s_d;

  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic       sub_rise;
  logic       t8;
  logic       t32;
  logic       tsub;
  logic       accept;
  logic       wr_en;
  logic [1:0] tick_w;
  logic [1:0] edge_w;
  logic [1:0] wtmr_w;
  logic [1:0] wmode_w;

  mtb_sync_if u_pin_if [2] ();
  mtb_sync_if u_sub_if ();

  for (genvar k = 0; k < 2; k++) begin : g_pin
    mtb_pin_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_pin      (i_channel_pulse_input_pin[k]),
      .o_sync     (u_pin_if[k])
    );
    assign pin_rise[k] = u_pin_if[k].rise;
    assign pin_fall[k] = u_pin_if[k].fall;
  end

  mtb_pin_sync u_sub_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_pin      (i_sub_clock_pin),
    .o_sync     (u_sub_if)
  );
  assign sub_rise = u_sub_if.rise;

  // read mux, sampled one cycle after the address phase
  function automatic logic [31:0] rd_mux(input mtb_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (s.addr == mtb_pkg::OFF_CTRL) begin
      r[1:0] = s.start;
    end
    for (int c = 0; c < 2; c++) begin
      if (s.addr == mtb_pkg::mode_off(c)) begin
        r[5:0] = s.mode[c];
        r[mtb_pkg::OVF_POS] = s.ovf[c];
      end
      if (s.addr == mtb_pkg::tmr_off(c)) begin
        if (s.mode[c][1:0] == mtb_pkg::MTB_MEAS) begin
          r[15:0] = s.rld[c];
        end else begin
          r[15:0] = s.cnt[c];
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [1:0] md;
    logic [1:0] es;
    logic       cev;
    md      = 2'h0;
    es      = 2'h0;
    cev     = 1'b0;
    s_d     = s_q;
    tick_w  = 2'h0;
    edge_w  = 2'h0;
    wtmr_w  = 2'h0;
    wmode_w = 2'h0;

    // bus slave: reads stall one cycle so a preceding write is visible
    o_hreadyout = !(s_q.act && !s_q.wr && !s_q.rd_wait);
    o_hresp     = 1'b0;
    o_hrdata    = s_q.rdata;
    accept      = i_hsel && i_htrans[1] && i_hready;
    wr_en       = s_q.act && s_q.wr;
    if (o_hreadyout) begin
      s_d.act     = accept;
      s_d.wr      = i_hwrite;
      s_d.rd_wait = 1'b0;
      s_d.addr    = (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : mtb_pkg::OFF_NONE;
    end else begin
      s_d.rd_wait = 1'b1;
      s_d.rdata   = rd_mux(s_q);
    end

    // prescaler and sub-clock divider
    s_d.presc = s_q.presc + 5'h01;
    t8        = (s_q.presc[2:0] == 3'(mtb_pkg::DIV8 - 1));
    t32       = (s_q.presc == 5'(mtb_pkg::DIV32 - 1));
    tsub      = sub_rise && (s_q.subdiv == 5'(mtb_pkg::DIV32 - 1));
    if (sub_rise) begin
      s_d.subdiv = s_q.subdiv + 5'h01;
    end

    if (wr_en && s_q.addr == mtb_pkg::OFF_CTRL) begin
      s_d.start = i_hwdata[1:0];
    end

    for (int c = 0; c < 2; c++) begin
      md         = s_q.mode[c][mtb_pkg::MODE_LSB +: 2];
      es         = s_q.mode[c][mtb_pkg::EDGE_LSB +: 2];
      tick_w[c]  = mtb_pkg::sel_tick(s_q.mode[c][mtb_pkg::SRC_LSB +: 2], t8, t32, tsub);
      edge_w[c]  = mtb_pkg::eff_edge(es, pin_rise[c], pin_fall[c]);
      wtmr_w[c]  = wr_en && (s_q.addr == mtb_pkg::tmr_off(c));
      wmode_w[c] = wr_en && (s_q.addr == mtb_pkg::mode_off(c));
      s_d.irq[c] = 1'b0;

      if (wmode_w[c]) begin
        s_d.mode[c] = i_hwdata[5:0];
        if (s_q.start[c]) begin
          s_d.ovf[c] = 1'b0;
        end
      end

      case (md)
        mtb_pkg::MTB_TIMER, mtb_pkg::MTB_EVENT: begin
          cev = (md == mtb_pkg::MTB_TIMER) ? tick_w[c] : edge_w[c];
          if (s_q.start[c] && cev) begin
            if (s_q.cnt[c] == 16'h0000) begin
              s_d.cnt[c] = s_q.rld[c];
              s_d.irq[c] = 1'b1;
            end else begin
              s_d.cnt[c] = s_q.cnt[c] - 16'h0001;
            end
          end
          if (wtmr_w[c]) begin
            s_d.rld[c] = i_hwdata[15:0];
            if (!s_q.start[c]) begin
              s_d.cnt[c] = i_hwdata[15:0];
            end
          end
        end
        mtb_pkg::MTB_MEAS: begin
          // timer register writes fall through unused here
          if (s_q.start[c]) begin
            if (edge_w[c]) begin
              s_d.rld[c]  = s_q.cnt[c];
              s_d.cnt[c]  = 16'h0000;
              s_d.seen[c] = 1'b1;
              s_d.irq[c]  = s_q.seen[c];
            end else if (tick_w[c]) begin
              s_d.cnt[c] = s_q.cnt[c] + 16'h0001;
              if (s_q.cnt[c] == mtb_pkg::CNT_MAX) begin
                s_d.ovf[c] = 1'b1;
                s_d.irq[c] = 1'b1;
              end
            end
          end
        end
        default: begin
        end
      endcase

      // first capture after a start is partial, so its request is held back
      if (!s_q.start[c]) begin
        s_d.seen[c] = 1'b0;
      end
    end

    o_irq_req = s_q.irq;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q       <= '0;
      s_q.addr  <= mtb_pkg::OFF_NONE;
      s_q.start <= mtb_pkg::START_RST;
      s_q.mode  <= {2{mtb_pkg::MODE_RST}};
      s_q.cnt   <= {2{mtb_pkg::TMR_RST}};
      s_q.rld   <= {2{mtb_pkg::TMR_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // checks on channel 0; channel 1 is the same logic
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic       run0;
  logic [1:0] md0;
  assign run0 = s_q.start[0];
  assign md0  = s_q.mode[0][1:0];

  stop_hold_a: assert property (
    !run0 && !wtmr_w[0] |=> $stable(s_q.cnt[0]))
    else $error("counter moved while stopped");

  down_step_a: assert property (
    run0 && md0 == mtb_pkg::MTB_TIMER && tick_w[0] && s_q.cnt[0] != 16'h0000 && !wtmr_w[0]
    |=> s_q.cnt[0] == $past(s_q.cnt[0]) - 16'h0001)
    else $error("timer did not step down");

  underflow_reload_a: assert property (
    run0 && md0 != mtb_pkg::MTB_MEAS && md0 != mtb_pkg::MTB_RSVD
    && (md0 == mtb_pkg::MTB_TIMER ? tick_w[0] : edge_w[0]) && s_q.cnt[0] == 16'h0000
    |=> s_q.cnt[0] == $past(s_q.rld[0]) && o_irq_req[0])
    else $error("underflow did not reload and request");

  stop_write_a: assert property (
    !run0 && md0 == mtb_pkg::MTB_TIMER && wtmr_w[0]
    |=> s_q.cnt[0] == $past(i_hwdata[15:0]) && s_q.rld[0] == s_q.cnt[0])
    else $error("stopped write not loaded to both");

  capture_a: assert property (
    run0 && md0 == mtb_pkg::MTB_MEAS && edge_w[0]
    |=> s_q.cnt[0] == 16'h0000 && s_q.rld[0] == $past(s_q.cnt[0]))
    else $error("edge did not capture and restart");

  first_edge_a: assert property (
    run0 && md0 == mtb_pkg::MTB_MEAS && edge_w[0] && !s_q.seen[0] |=> !o_irq_req[0])
    else $error("first edge raised a request");

  ovf_set_a: assert property (
    run0 && md0 == mtb_pkg::MTB_MEAS && tick_w[0] && !edge_w[0] && s_q.cnt[0] == 16'hFFFF
    |=> s_q.ovf[0] && o_irq_req[0] && s_q.cnt[0] == 16'h0000)
    else $error("overflow not flagged");

  meas_nowrite_a: assert property (
    md0 == mtb_pkg::MTB_MEAS && wtmr_w[0] && !edge_w[0] |=> $stable(s_q.rld[0]))
    else $error("measurement result overwritten");

  ovf_clear_a: assert property (
    run0 && wmode_w[0] && !(tick_w[0] && md0 == mtb_pkg::MTB_MEAS) |=> !s_q.ovf[0])
    else $error("overflow flag not cleared");

  // reads stall one cycle: the mux samples in the wait cycle, after any write has landed
  read_stall_a: assert property (
    accept && !i_hwrite && o_hreadyout |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state missing");

  read_count_a: assert property (
    s_q.act && !s_q.wr && !s_q.rd_wait && s_q.addr == mtb_pkg::tmr_off(0) && md0 != mtb_pkg::MTB_MEAS
    |=> o_hrdata[15:0] == $past(s_q.cnt[0]))
    else $error("timer read is not the running count");

  read_result_a: assert property (
    s_q.act && !s_q.wr && !s_q.rd_wait && s_q.addr == mtb_pkg::tmr_off(0) && md0 == mtb_pkg::MTB_MEAS
    |=> o_hrdata[15:0] == $past(s_q.rld[0]))
    else $error("measurement read is not the result");

  ovf_hold_a: assert property (
    s_q.ovf[0] && !(run0 && wmode_w[0]) |=> s_q.ovf[0])
    else $error("overflow flag lost without a clearing write");

  stop_quiet_a: assert property (
    !run0 |=> !o_irq_req[0])
    else $error("request raised while stopped");

  event_step_a: assert property (
    run0 && md0 == mtb_pkg::MTB_EVENT && edge_w[0] && s_q.cnt[0] != 16'h0000
    |=> s_q.cnt[0] == $past(s_q.cnt[0]) - 16'h0001)
    else $error("event edge did not step down");

  meas_up_a: assert property (
    run0 && md0 == mtb_pkg::MTB_MEAS && tick_w[0] && !edge_w[0] && s_q.cnt[0] != mtb_pkg::CNT_MAX
    |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 16'h0001)
    else $error("measurement count did not step up");

  run_write_a: assert property (
    run0 && (md0 == mtb_pkg::MTB_TIMER || md0 == mtb_pkg::MTB_EVENT) && wtmr_w[0]
    |=> s_q.rld[0] == $past(i_hwdata[15:0])
    && (s_q.cnt[0] == $past(s_q.cnt[0]) || s_q.cnt[0] == $past(s_q.cnt[0]) - 16'h0001
    || s_q.cnt[0] == $past(s_q.rld[0])))
    else $error("running write reached the counter");

  underflow_c: cover property (run0 && md0 == mtb_pkg::MTB_TIMER ##1 o_irq_req[0]);
  event_c:     cover property (run0 && md0 == mtb_pkg::MTB_EVENT && edge_w[0]);
  capture_c:   cover property (run0 && md0 == mtb_pkg::MTB_MEAS && edge_w[0] ##1 o_irq_req[0]);
  overflow_c:  cover property (s_q.ovf[0] ##1 !s_q.ovf[0]);
  width_c:     cover property (run0 && md0 == mtb_pkg::MTB_MEAS
                               && s_q.mode[0][3:2] == mtb_pkg::EDGE_BOTH && edge_w[0]);

endmodule

/* mtb_timer_top_tb_top.sv */
// Purpose: self-checking bench of the two-channel measuring timer
// Assumes: one AHB-Lite master, pulse source model on the channel pins
// Notes:   interrupt spacing and read data are checked against queued notes
`timescale 1ns/10ps
module mtb_timer_top_tb_top;
  typedef struct {int gap; int tol;} mtb_note_t;
  localparam int BIG = 1000000;
  logic        clk, rst_b, hsel, hwrite, sub, rdy_s, rph;
  logic [31:0] haddr, hwdata, seed;
  logic [1:0]  htrans, run;
  logic [2:0]  hsize;
  logic [15:0] half;
  wire  [31:0] hrdata;
  wire  [1:0]  irq, pin;
  wire         hready, hresp;
  int          err_total, tests_run, cyc, last [2];
  logic [31:0] rq [$];
  mtb_note_t   gq [2][$];

  mtb_timer_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_channel_pulse_input_pin(pin),
    .i_sub_clock_pin(sub), .o_irq_req(irq));
  mtb_pulse_src i_src (.i_core_clk(clk), .i_run(run), .i_half(half), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // sub-clock at a quarter of the core rate
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sub <= cyc[1];
  end
  always @(negedge clk) rdy_s = hready;
  always @(posedge clk) if (rdy_s) rph <= hsel & htrans[1] & ~hwrite;

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic fail_out(input string m);
    chk(1'b0, m);
    print_verdict();
  endtask

  // results arrive here; each takes the oldest note
  always @(negedge clk) begin
    int d;
    if (rph && hready === 1'b1 && rq.size() > 0) begin
      chk(hrdata === rq[0] && hresp === 1'b0, "read data");
      void'(rq.pop_front());
    end
    for (int c = 0; c < 2; c++) begin
      if (irq[c] === 1'b1) begin
        d = cyc - last[c];
        if (gq[c].size() == 0) chk(1'b0, "unexpected interrupt");
        else begin
          chk(d >= gq[c][0].gap - gq[c][0].tol && d <= gq[c][0].gap + gq[c][0].tol, "interrupt spacing");
          void'(gq[c].pop_front());
        end
        last[c] = cyc;
      end
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (rdy_s !== 1'b1) fail_out("bus hang");
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic note(input int c, input int g, input int t);
    gq[c].push_back('{g, t});
  endtask

  task automatic start(input int c);
    wr(mtb_pkg::OFF_CTRL, 32'(1 << c));
    last[c] = cyc;
  endtask

  // a stray interrupt after this stop shows up as unexpected
  task automatic drain_stop(input int c);
    for (int n = 0; gq[c].size() > 0 && n < 70000; n++) @(posedge clk);
    if (gq[c].size() > 0) fail_out("interrupt missing");
    wr(mtb_pkg::OFF_CTRL, 32'h00000000);
  endtask

  initial begin
    int n, h, p, t1;
    logic [31:0] v;
    {hsel, hwrite, htrans, haddr, hwdata, run, sub, rph, rdy_s} = '0;
    hsize     = 3'h2;
    half      = 16'h0006;
    cyc       = 0;
    last[0]   = 0;
    last[1]   = 0;
    seed      = 32'hEEC365DB;
    err_total = 0;
    tests_run = 0;
    rst_b     = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(mtb_pkg::OFF_CTRL, 32'h00000000);
    rd(mtb_pkg::OFF_NONE, 32'h00000000);
    for (int c = 0; c < 2; c++) begin
      rd(mtb_pkg::mode_off(c), 32'h00000000);
      rd(mtb_pkg::tmr_off(c), 32'h00000000);
      v = rnd() & 32'h0000FFFF;
      wr(mtb_pkg::tmr_off(c), v);
      rd(mtb_pkg::tmr_off(c), v);
      for (int s = 0; s < 4; s++) begin
        n = 6 + int'(rnd() % 3);
        p = (n + 1) * (s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 128);
        wr(mtb_pkg::mode_off(c), 32'(s << 4));
        wr(mtb_pkg::tmr_off(c), 32'(n));
        start(c);
        note(c, 0, BIG);
        note(c, p, 0);
        note(c, p, 0);
        drain_stop(c);
      end
      wr(mtb_pkg::mode_off(c), 32'h00000000);
      wr(mtb_pkg::tmr_off(c), 32'h00000006);
      start(c);
      note(c, 0, BIG);
      for (int n2 = 0; n2 < 100 && gq[c].size() > 0; n2++) @(posedge clk);
      wr(mtb_pkg::tmr_off(c), 32'h00000009);
      note(c, 7, 0);
      note(c, 10, 0);
      note(c, 10, 0);
      drain_stop(c);
      h = 6 + int'(rnd() % 4);
      half    <= 16'(h);
      run[c]  <= 1'b1;
      for (int e = 0; e < 3; e++) begin
        n = 2 + int'(rnd() % 2);
        wr(mtb_pkg::mode_off(c), 32'(1 | (e << 2)));
        wr(mtb_pkg::tmr_off(c), 32'(n));
        start(c);
        note(c, 0, BIG);
        note(c, (n + 1) * h * (e == 2 ? 1 : 2), 0);
        drain_stop(c);
      end
      run[c] <= 1'b0;
      for (int w = 0; w < 2; w++) begin
        h = 6 + int'(rnd() % 4);
        p = (w == 1) ? h : 2 * h;
        wr(mtb_pkg::mode_off(c), 32'(2 | (w << 3)));
        start(c);
        @(posedge clk);
        t1 = (w == 1 || pin[c] === 1'b0) ? h : 2 * h;
        half    <= 16'(h);
        run[c]  <= 1'b1;
        last[c] = cyc;
        note(c, t1 + p + 4, 4);
        note(c, p, 0);
        for (int n2 = 0; n2 < 200 && gq[c].size() > 0; n2++) @(posedge clk);
        // stop first: the pulse keeps running and would raise requests that no note expects
        drain_stop(c);
        rd(mtb_pkg::tmr_off(c), 32'(p - 1));
        wr(mtb_pkg::tmr_off(c), 32'h00001234);
        rd(mtb_pkg::tmr_off(c), 32'(p - 1));
        run[c] <= 1'b0;
      end
    end
    wr(mtb_pkg::mode_off(0), 32'h00000000);
    wr(mtb_pkg::tmr_off(0), 32'h00000000);
    wr(mtb_pkg::mode_off(0), 32'h00000002);
    start(0);
    note(0, 65536, 4);
    for (int n2 = 0; n2 < 70000 && gq[0].size() > 0; n2++) @(posedge clk);
    rd(mtb_pkg::mode_off(0), 32'h00000082);
    wr(mtb_pkg::mode_off(0), 32'h00000002);
    rd(mtb_pkg::mode_off(0), 32'h00000002);
    drain_stop(0);
    // idle mode: started but never counts nor requests
    wr(mtb_pkg::mode_off(0), 32'h00000000);
    wr(mtb_pkg::tmr_off(0), 32'h00000055);
    wr(mtb_pkg::mode_off(0), 32'h00000003);
    start(0);
    repeat (20) @(posedge clk);
    rd(mtb_pkg::tmr_off(0), 32'h00000055);
    repeat (20) @(posedge clk);
    print_verdict();
  end
endmodule
